// ---- src/pvip_defs.svh ----
// register offsets, field positions, reset values and timing counts of the oscillator register port
`ifndef PVIP_DEFS_SVH
`define PVIP_DEFS_SVH

`define PVIP_ADDR_ID 5'h00
`define PVIP_ADDR_RST 5'h01
`define PVIP_ADDR_REFERENCE_DIVIDE 5'h02
`define PVIP_ADDR_PACKET 5'h05
`define PVIP_ADDR_LINKCFG 5'h0a

`define PVIP_RST_RESET 10'h002
`define PVIP_REFERENCE_DIVIDE_RESET 14'h0001
`define PVIP_RATE_RESET 2'h1
`define PVIP_PACKET_RESET 16'h0000

`define PVIP_PTR_MSB 4
`define PVIP_PTR_LSB 0
`define PVIP_SOFTRST_BIT 5
`define PVIP_RATE_MSB 14
`define PVIP_RATE_LSB 13
`define PVIP_PKT_SEL_MSB 2
`define PVIP_PKT_SEL_LSB 0
`define PVIP_PKT_IDX_MSB 6
`define PVIP_PKT_IDX_LSB 3
`define PVIP_PKT_DATA_MSB 15
`define PVIP_PKT_DATA_LSB 7
`define PVIP_PACKET_BITS 16
`define PVIP_LAST_BIT 4'hf

`define PVIP_CLK_MHZ 40
`define PVIP_LINK_MAX_MHZ 50
`define PVIP_LINK_MIN_CYC ((`PVIP_CLK_MHZ + `PVIP_LINK_MAX_MHZ - 1) / `PVIP_LINK_MAX_MHZ)

`endif

// ---- src/pvip_pkg.sv ----
// types shared by the oscillator register port
package pvip_pkg;
	typedef logic [15:0] pvip_packet_t;
	typedef enum logic [0:0] {
		PVIP_IDLE = 1'b0,
		PVIP_SHIFT = 1'b1
	} pvip_link_state_t;
endpackage

// ---- src/pvip_clk_div.sv ----
// divider that makes the internal oscillator link clock from the reference clock
`timescale 1ns/1ps
`default_nettype none
`include "pvip_defs.svh"

module pvip_clk_div (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [1:0] rateSel,
	output logic linkClk,
	output logic fallTick
);
	logic [4:0] cnt_q;
	logic [4:0] cnt_d;
	logic linkClk_q;
	wire [4:0] lastCount;
	wire [4:0] halfCount;

	// period is 2 << rateSel cycles, so setting 1 divides by four
	assign lastCount = 5'((5'h2 << rateSel) - 5'h1);
	assign halfCount = 5'(5'h1 << rateSel);
	assign fallTick = (cnt_q >= lastCount);
	assign cnt_d = fallTick ? 5'h00 : 5'(cnt_q + 5'h01);
	assign linkClk = linkClk_q;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cnt_q <= 5'h00;
			linkClk_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			linkClk_q <= (cnt_d >= halfCount);
		end
	end

	AST_LINK_MAX_RATE: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(linkClk) |=> !$rose(linkClk))
		else $error("link clock rose on two clock edges in a row");
	AST_LINK_PERIOD: assert property (@(posedge clock) disable iff (!rst_b)
		(32'(lastCount) + 32'd1) >= 2 * `PVIP_LINK_MIN_CYC)
		else $error("link period shorter than the limit allows");
endmodule // pvip_clk_div
`default_nettype wire

// ---- src/pvip_link_shift.sv ----
// serialiser that sends one 16-bit packet over the internal oscillator link
`timescale 1ns/1ps
`default_nettype none
`include "pvip_defs.svh"

module pvip_link_shift (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic fallTick,
	input wire logic startReq,
	input wire pvip_pkg::pvip_packet_t packet,
	output logic accepted,
	output logic linkData,
	output logic linkFrame,
	output logic done
);
	pvip_pkg::pvip_link_state_t state_q;
	pvip_pkg::pvip_packet_t shift_q;
	logic [3:0] bitCnt_q;
	logic frame_q;
	logic done_q;

	assign accepted = (state_q == pvip_pkg::PVIP_IDLE) && startReq && fallTick;
	assign linkData = shift_q[`PVIP_PACKET_BITS-1];
	assign linkFrame = frame_q;
	assign done = done_q;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_q <= pvip_pkg::PVIP_IDLE;
			shift_q <= `PVIP_PACKET_RESET;
			bitCnt_q <= 4'h0;
			frame_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				pvip_pkg::PVIP_IDLE: begin
					if (accepted) begin
						shift_q <= packet;
						bitCnt_q <= 4'h0;
						frame_q <= 1'b1;
						state_q <= pvip_pkg::PVIP_SHIFT;
					end
				end
				pvip_pkg::PVIP_SHIFT: begin
					if (fallTick) begin
						if (bitCnt_q == `PVIP_LAST_BIT) begin
							frame_q <= 1'b0;
							done_q <= 1'b1;
							shift_q <= `PVIP_PACKET_RESET;
							state_q <= pvip_pkg::PVIP_IDLE;
						end else begin
							shift_q <= {shift_q[`PVIP_PACKET_BITS-2:0], 1'b0};
							bitCnt_q <= 4'(bitCnt_q + 4'h1);
						end
					end
				end
				default: begin
					state_q <= pvip_pkg::PVIP_IDLE;
					frame_q <= 1'b0;
				end
			endcase
		end
	end

	AST_MSB_FIRST: assert property (@(posedge clock) disable iff (!rst_b)
		accepted |=> (linkData == $past(packet[`PVIP_PACKET_BITS-1])) && linkFrame)
		else $error("first link bit is not the packet msb");
endmodule // pvip_link_shift
`default_nettype wire

// ---- src/pvip_reg_port.sv ----
// register bank front and indirect oscillator packet forwarding
//
// Function
// - A host write of the packet register sends it msb first over the link; a newer write replaces one still waiting.
// - Link packets are sixteen bits long.
// - Link runs on calibration machine clock, never above 50 MHz.
// - Field 14:13 of register 0Ah picks link rate; default 1 divides by four.
// - Packet: bits 2:0 subsystem select, 6:3 register index, 15:7 data.
// - Calibration updates only the packet data field, never select or index.
// - Register 00h reads a fixed 24-bit identity and is read only.
// - Write to 00h stores bits 4:0 as next read address.
// - Bit 5 written to 00h soft-resets the serial interface; keep zero normally.
// - Register 01h resets to 000002h, all fields reserved.
// - Register 02h holds reference divide 13:0, reset 1, range 1 to 16383.
// - Packet register reads back the last packet written or calibrated, nothing more.
`timescale 1ns/1ps
`default_nettype none
`include "pvip_defs.svh"

module pvip_reg_port #(
	// arbitrary value, not tied to any real part
	parameter logic [23:0] DEVICE_ID = 24'h5a0c31
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic regWrite,
	input wire logic [4:0] regAddr,
	input wire logic [23:0] regWrData,
	output logic [23:0] regRdData,
	output logic serialSoftReset,
	input wire logic calUpdate,
	input wire logic [8:0] calData,
	output logic [13:0] refDivideValue,
	output logic [9:0] resetControl,
	output logic linkBusy,
	output logic oscLinkClk,
	output logic oscLinkData,
	output logic oscLinkFrame
);
	////////////////////////////////////////////////////////////////////////////////
	logic [4:0] readPtr_q;
	logic softReset_q;
	logic [9:0] rstReg_q;
	logic [13:0] reference_divide_q;
	logic [1:0] rateSel_q;
	pvip_pkg::pvip_packet_t packet_q;
	pvip_pkg::pvip_packet_t packet_d;
	logic pending_q;
	logic [23:0] rdData_q;
	logic fallTick;
	logic accepted;
	logic frameDone;

	wire wrId = regWrite && (regAddr == `PVIP_ADDR_ID);
	wire wrRst = regWrite && (regAddr == `PVIP_ADDR_RST);
	wire wrRefDiv = regWrite && (regAddr == `PVIP_ADDR_REFERENCE_DIVIDE);
	wire wrPkt = regWrite && (regAddr == `PVIP_ADDR_PACKET);
	wire wrLinkCfg = regWrite && (regAddr == `PVIP_ADDR_LINKCFG);
	// zero divide is out of range and is dropped
	wire refDivOk = (regWrData[13:0] != 14'h0000);
	wire calOnly = calUpdate && !wrPkt;

	// read data for the address held in the read pointer
	function automatic logic [23:0] readMux(
		input logic [4:0] addr,
		input logic [9:0] rstVal,
		input logic [13:0] divVal,
		input logic [15:0] pktVal,
		input logic [1:0] rateVal
	);
		logic [23:0] value;
		value = 24'h000000;
		case (addr)
			`PVIP_ADDR_ID: value = DEVICE_ID;
			`PVIP_ADDR_RST: value = {14'h0000, rstVal};
			`PVIP_ADDR_REFERENCE_DIVIDE: value = {10'h000, divVal};
			`PVIP_ADDR_PACKET: value = {8'h00, pktVal};
			`PVIP_ADDR_LINKCFG: value = 24'(rateVal) << `PVIP_RATE_LSB;
			default: value = 24'h000000;
		endcase
		return value;
	endfunction

	assign packet_d = wrPkt ? regWrData[15:0] :
		calUpdate ? {calData, packet_q[`PVIP_PKT_IDX_MSB:`PVIP_PKT_SEL_LSB]} : packet_q;

	assign regRdData = rdData_q;
	assign serialSoftReset = softReset_q;
	assign refDivideValue = reference_divide_q;
	assign resetControl = rstReg_q;
	assign linkBusy = pending_q || oscLinkFrame;

	////////////////////////////////////////////////////////////////////////////////
	// register bank
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			readPtr_q <= 5'h00;
			softReset_q <= 1'b0;
			rstReg_q <= `PVIP_RST_RESET;
			reference_divide_q <= `PVIP_REFERENCE_DIVIDE_RESET;
			rateSel_q <= `PVIP_RATE_RESET;
			packet_q <= `PVIP_PACKET_RESET;
			rdData_q <= 24'h000000;
		end else begin
			if (wrId) begin
				readPtr_q <= regWrData[`PVIP_PTR_MSB:`PVIP_PTR_LSB];
			end
			softReset_q <= wrId && regWrData[`PVIP_SOFTRST_BIT];
			if (wrRst) begin
				rstReg_q <= regWrData[9:0];
			end
			if (wrRefDiv && refDivOk) begin
				reference_divide_q <= regWrData[13:0];
			end
			if (wrLinkCfg) begin
				rateSel_q <= regWrData[`PVIP_RATE_MSB:`PVIP_RATE_LSB];
			end
			packet_q <= packet_d;
			rdData_q <= readMux(readPtr_q, rstReg_q, reference_divide_q, packet_q, rateSel_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// forwarding: a new packet waits until the link is idle
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pending_q <= 1'b0;
		end else begin
			pending_q <= (wrPkt || calUpdate) || (pending_q && !accepted);
		end
	end

	pvip_clk_div u_div (
		.clock(clock),
		.rst_b(rst_b),
		.rateSel(rateSel_q),
		.linkClk(oscLinkClk),
		.fallTick(fallTick)
	);

	pvip_link_shift u_shift (
		.clock(clock),
		.rst_b(rst_b),
		.fallTick(fallTick),
		.startReq(pending_q),
		.packet(packet_q),
		.accepted(accepted),
		.linkData(oscLinkData),
		.linkFrame(oscLinkFrame),
		.done(frameDone)
	);

	////////////////////////////////////////////////////////////////////////////////
	// checks
	logic [4:0] bitsSeen_q;
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			bitsSeen_q <= 5'h00;
		end else if (!oscLinkFrame) begin
			bitsSeen_q <= 5'h00;
		end else if (fallTick) begin
			bitsSeen_q <= 5'(bitsSeen_q + 5'h01);
		end
	end

	AST_PKT_FORWARD: assert property (@(posedge clock) disable iff (!rst_b)
		wrPkt |-> ##[1:600] accepted)
		else $error("packet write never reached the link");
	AST_PKT_WIDTH: assert property (@(posedge clock) disable iff (!rst_b)
		$fell(oscLinkFrame) |-> (bitsSeen_q == 5'h10) && frameDone)
		else $error("link packet is not sixteen bits");
	AST_RATE_DIV4: assert property (@(posedge clock) disable iff (!rst_b)
		($rose(oscLinkClk) && rateSel_q == 2'h1 && $stable(rateSel_q)) |-> oscLinkClk[*2] ##1 !oscLinkClk)
		else $error("rate setting one does not divide by four");
	AST_RATE_RESET: assert property (@(posedge clock) disable iff (!rst_b)
		!$past(rst_b) |-> rateSel_q == `PVIP_RATE_RESET)
		else $error("link rate field wrong after reset");
	AST_CAL_FIELDS: assert property (@(posedge clock) disable iff (!rst_b)
		calOnly |=> (packet_q[6:0] == $past(packet_q[6:0])) && (packet_q[15:7] == $past(calData)))
		else $error("calibration touched select or index");
	AST_ID_READ: assert property (@(posedge clock) disable iff (!rst_b)
		(readPtr_q == `PVIP_ADDR_ID) |=> regRdData == DEVICE_ID)
		else $error("identity read wrong");
	AST_PTR_STORE: assert property (@(posedge clock) disable iff (!rst_b)
		wrId |=> ##1 (regRdData == readMux($past(regWrData[4:0], 2), rstReg_q, reference_divide_q, packet_q, rateSel_q))
			|| !$stable(packet_q) || !$stable(rateSel_q) || !$stable(reference_divide_q) || !$stable(rstReg_q))
		else $error("read pointer not applied to next read");
	AST_SOFT_RESET: assert property (@(posedge clock) disable iff (!rst_b)
		(wrId && regWrData[5]) |=> serialSoftReset ##1 (serialSoftReset == $past(wrId && regWrData[5])))
		else $error("soft reset strobe wrong");
	AST_RST_DEFAULT: assert property (@(posedge clock) disable iff (!rst_b)
		!$past(rst_b) |-> resetControl == 10'h002)
		else $error("reset register default wrong");
	AST_REFERENCE_DIVIDE: assert property (@(posedge clock) disable iff (!rst_b)
		(!$past(rst_b) |-> refDivideValue == 14'h0001) and (refDivideValue != 14'h0000))
		else $error("reference divide out of range");
	AST_READBACK: assert property (@(posedge clock) disable iff (!rst_b)
		(readPtr_q == `PVIP_ADDR_PACKET) |=> regRdData == {8'h00, $past(packet_q)})
		else $error("packet readback wrong");
	AST_ONE_FRAME: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(oscLinkFrame) |=> (oscLinkFrame && !accepted)[*8])
		else $error("packet cut short by the next one");

	COV_WRITE_BUSY: cover property (@(posedge clock) disable iff (!rst_b) wrPkt && oscLinkFrame);
	COV_FRAME_DONE: cover property (@(posedge clock) disable iff (!rst_b) frameDone);
	COV_CAL: cover property (@(posedge clock) disable iff (!rst_b) calOnly ##[1:600] accepted);
	COV_SOFT: cover property (@(posedge clock) disable iff (!rst_b) serialSoftReset);
endmodule // pvip_reg_port
`default_nettype wire

// ---- bench/pvip_osc_model.sv ----
// receiving end of the internal oscillator link
`timescale 1ns/1ps
`default_nettype none
module pvip_osc_model (
	input wire logic linkClk,
	input wire logic linkData,
	input wire logic linkFrame,
	output logic [15:0] lastPacket,
	output logic [7:0] rxCount,
	output logic [4:0] lastBits
);
	logic [15:0] shiftQ;
	logic [4:0] bitsQ;
	initial begin
		lastPacket = 16'h0000;
		rxCount = 8'h00;
		lastBits = 5'h00;
		shiftQ = 16'h0000;
		bitsQ = 5'h00;
	end
	always @(posedge linkClk) begin
		if (linkFrame) begin
			shiftQ <= {shiftQ[14:0], linkData};
			bitsQ <= bitsQ + 5'h01;
		end
	end
	always @(negedge linkFrame) begin
		lastPacket <= shiftQ;
		lastBits <= bitsQ;
		rxCount <= rxCount + 8'h01;
		bitsQ <= 5'h00;
	end
endmodule // pvip_osc_model
`default_nettype wire

// ---- bench/test_pvip_reg_port.sv ----
// self-checking bench of the oscillator register port
`timescale 1ns/1ps
`default_nettype none
`include "pvip_defs.svh"
module test_pvip_reg_port;
	// arbitrary identity value
	localparam logic [23:0] ID = 24'h3c5a96;
	logic clock, rst_b, regWrite, calUpdate, serialSoftReset, linkBusy, oscLinkClk, oscLinkData, oscLinkFrame;
	logic [4:0] regAddr, lastBits;
	logic [23:0] regWrData, regRdData, rd;
	logic [8:0] calData;
	logic [13:0] refDivideValue;
	logic [9:0] resetControl;
	logic [15:0] lastPacket;
	logic [7:0] rxCount, base;
	int n_mismatch, n_compared, cyc, srCount;
	longint t0;
	pvip_reg_port #(.DEVICE_ID(ID)) DUT (
		.clock(clock),
		.rst_b(rst_b),
		.regWrite(regWrite),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regRdData(regRdData),
		.serialSoftReset(serialSoftReset),
		.calUpdate(calUpdate),
		.calData(calData),
		.refDivideValue(refDivideValue),
		.resetControl(resetControl),
		.linkBusy(linkBusy),
		.oscLinkClk(oscLinkClk),
		.oscLinkData(oscLinkData),
		.oscLinkFrame(oscLinkFrame)
	);
	pvip_osc_model osc (
		.linkClk(oscLinkClk),
		.linkData(oscLinkData),
		.linkFrame(oscLinkFrame),
		.lastPacket(lastPacket),
		.rxCount(rxCount),
		.lastBits(lastBits)
	);
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (serialSoftReset === 1'b1)
			srCount <= srCount + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			n_mismatch++;
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [23:0] d);
		regAddr = a;
		regWrData = d;
		regWrite = 1'b1;
		@(negedge clock);
		regWrite = 1'b0;
		@(negedge clock);
	endtask
	task automatic rdReg(input logic [4:0] a, output logic [23:0] d);
		wr(`PVIP_ADDR_ID, {19'h0, a});
		@(negedge clock);
		d = regRdData;
	endtask
	task automatic waitIdle();
		repeat (4) @(negedge clock);
		while (linkBusy !== 1'b0)
			@(negedge clock);
		repeat (4) @(negedge clock);
	endtask
	task automatic waitFrame();
		while (oscLinkFrame !== 1'b1)
			@(negedge clock);
	endtask
	initial begin
		n_mismatch = 0;
		n_compared = 0;
		cyc = 0;
		srCount = 0;
		rst_b = 1'b0;
		regWrite = 1'b0;
		regAddr = 5'h00;
		regWrData = 24'h000000;
		calUpdate = 1'b0;
		calData = 9'h000;
		repeat (3) @(negedge clock);
		rst_b = 1'b1;
		@(negedge clock);
		rdReg(`PVIP_ADDR_ID, rd);
		chk(rd, ID);
		chk({14'h0, resetControl}, 24'h000002);
		chk({10'h0, refDivideValue}, 24'h000001);
		rdReg(`PVIP_ADDR_LINKCFG, rd);
		chk(rd, 24'h002000);
		rdReg(5'h1f, rd);
		chk(rd, 24'h000000);
		wr(`PVIP_ADDR_ID, 24'h000020);
		rdReg(`PVIP_ADDR_ID, rd);
		chk(rd, ID);
		chk(srCount[23:0], 24'h000001);
		wr(`PVIP_ADDR_REFERENCE_DIVIDE, 24'hff3fff);
		wr(`PVIP_ADDR_REFERENCE_DIVIDE, 24'h000000);
		chk({10'h0, refDivideValue}, 24'h003fff);
		wr(`PVIP_ADDR_RST, 24'hfff3ff);
		rdReg(`PVIP_ADDR_RST, rd);
		chk(rd, 24'h0003ff);
		wr(`PVIP_ADDR_PACKET, 24'h001f10);
		waitIdle();
		chk({8'h0, lastPacket}, 24'h001f10);
		chk({19'h0, lastBits}, 24'h000010);
		rdReg(`PVIP_ADDR_PACKET, rd);
		chk(rd, 24'h001f10);
		base = rxCount;
		wr(`PVIP_ADDR_PACKET, 24'h000008);
		waitFrame();
		wr(`PVIP_ADDR_PACKET, 24'h001234);
		wr(`PVIP_ADDR_PACKET, 24'hff4321);
		waitIdle();
		chk({8'h0, lastPacket}, 24'h004321);
		chk({16'h0, rxCount - base}, 24'h000002);
		calData = 9'h1a5;
		calUpdate = 1'b1;
		@(negedge clock);
		calUpdate = 1'b0;
		waitIdle();
		chk({8'h0, lastPacket}, 24'h00d2a1);
		rdReg(5'h10, rd);
		wr(`PVIP_ADDR_PACKET, {8'h0, rd[7:0], 8'h00});
		waitIdle();
		chk({8'h0, lastPacket}, {8'h0, rd[7:0], 8'h00});
		for (int r = 0; r < 4; r++) begin
			wr(`PVIP_ADDR_LINKCFG, 24'(r) << 13);
			wr(`PVIP_ADDR_PACKET, 24'h000a00);
			waitFrame();
			@(posedge oscLinkClk);
			t0 = $time;
			@(posedge oscLinkClk);
			chk(24'(($time - t0) / 25), 24'(2 << r));
			waitIdle();
			chk({8'h0, lastPacket}, 24'h000a00);
		end
		wr(`PVIP_ADDR_LINKCFG, 24'h002000);
		summarize();
	end
endmodule // test_pvip_reg_port
`default_nettype wire
